// ===== slpd_pkg.sv
// Package: timing constants and types for the serial-link auto powerdown block
package slpd_pkg;
	localparam int CLK_MHZ = 25;
	// Invalid-level persistence time before presence drops, in us
	localparam int INVALID_US = 30;
	localparam int INVALID_CYC = INVALID_US * CLK_MHZ;
	// Delay from valid level to presence rising, in us
	localparam int VALID_US = 1;
	localparam int VALID_CYC = VALID_US * CLK_MHZ;
	// Inactivity timeout, in seconds
	localparam int IDLE_S = 30;
	localparam longint IDLE_CYC_L = longint'(IDLE_S) * 64'd1000000 * longint'(CLK_MHZ);
	localparam logic [31:0] IDLE_CYC = IDLE_CYC_L[31:0];
	// Wake-up recovery time, in us
	localparam int WAKE_US = 100;
	localparam logic [31:0] WAKE_CYC = 32'(WAKE_US * CLK_MHZ);
	localparam int NUM_TX = 3;
	localparam int NUM_RX = 5;
	localparam int TMR_W = 32;
	localparam int PRES_W = 12;
	localparam logic [PRES_W-1:0] PRES_ZERO = 12'h000;
	localparam logic [TMR_W-1:0] TMR_ZERO = 32'h00000000;
	// Power state of the transceiver
	typedef enum logic [1:0] {
		PWR_OFF,
		PWR_WAKING,
		PWR_ON
	} slpd_pwr_type;
endpackage

// ===== slpd_sync.sv
// Two-stage synchroniser with rising/falling edge detect on the second stage
module slpd_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout,
	output logic any_edge
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} slpd_sync_type;
	slpd_sync_type st_q;
	slpd_sync_type st_d;

	// Stage one feeds only stage two
	always_comb begin
		st_d = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.s2;
	// Edge taken between stages two and three, never from stage one
	assign any_edge = |(st_q.s2 ^ st_q.s3);
endmodule

// ===== slpd_core.sv
// Serial-link presence detector and enhanced automatic powerdown controller
// Overview of operation
// - Presence output falls after invalid levels last 30 us on every receiver input.
// - Presence output rises 1 us after any receiver input shows a valid level.
// - The presence detector runs in every power mode.
// - The presence output never changes power state by itself.
// - With auto powerdown on, 30 s without input transitions turns pump and drivers off.
// - In auto powerdown any input transition powers the device back up.
// - Auto powerdown is active only with force-awake low and shutdown input high.
// - Force-awake high disables auto powerdown; shutdown low always wins and forces off.
// - After any powerdown the timer stays expired until force-awake rises or falls, or a transition.
// - Recovery from powerdown takes a wake-up delay of typically 100 us.
// - Floating receiver inputs read as invalid and pull the presence output low.
// - Presence wired to shutdown keeps the device down until presence and a transition.
// - In powerdown the drivers are high-impedance and the pump off; receivers stay on.
// - With force-awake low, manual powerdown ends on both force inputs high or a transition.
// - After force-awake falls the device stays up for 30 s even with no transitions.
module slpd_core (
	input wire logic mclk,
	input wire logic rst_n,
	// Logic-level transmitter inputs from the host
	input wire logic [slpd_pkg::NUM_TX-1:0] tx_in,
	// Receiver data, already sliced to logic levels
	input wire logic [slpd_pkg::NUM_RX-1:0] rx_data,
	// Per-receiver valid-level flags from the analog window comparators
	input wire logic [slpd_pkg::NUM_RX-1:0] rx_level_ok,
	input wire logic force_awake,
	input wire logic manual_shutdown_n,
	// Receiver outputs to the host, never tristated
	output logic [slpd_pkg::NUM_RX-1:0] rx_out,
	output logic line_present,
	output logic pump_en,
	output logic tx_drive_en,
	output logic tx_oe_n,
	output logic powered
);
	typedef struct packed {
		logic [slpd_pkg::PRES_W-1:0] pres_cnt;
		logic pres;
		logic [slpd_pkg::TMR_W-1:0] idle_cnt;
		logic expired;
		logic [slpd_pkg::TMR_W-1:0] wake_cnt;
		slpd_pkg::slpd_pwr_type pwr;
		logic fa_q;
		logic pump;
		logic drv;
		logic [slpd_pkg::NUM_RX-1:0] rxo;
	} slpd_core_type;

	slpd_core_type st_q;
	slpd_core_type st_d;

	logic [slpd_pkg::NUM_TX+slpd_pkg::NUM_RX-1:0] act_s;
	logic act_edge;
	logic [slpd_pkg::NUM_RX-1:0] lvl_s;
	logic [1:0] frc_s;
	logic [slpd_pkg::NUM_RX-1:0] rx_s;

	// Line activity: edge on any tx or rx input
	slpd_sync #(.W(slpd_pkg::NUM_TX + slpd_pkg::NUM_RX)) u_act_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.din({tx_in, rx_data}),
		.dout(act_s),
		.any_edge(act_edge)
	);

	// Valid-level flags; a floating input is pulled down so it reads invalid
	slpd_sync #(.W(slpd_pkg::NUM_RX)) u_lvl_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.din(rx_level_ok),
		.dout(lvl_s),
		.any_edge()
	);

	// Force pins come from outside, so they are synchronised too
	slpd_sync #(.W(2)) u_frc_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.din({force_awake, manual_shutdown_n}),
		.dout(frc_s),
		.any_edge()
	);

	assign rx_s = act_s[slpd_pkg::NUM_RX-1:0];

	logic fa;
	logic sd_n;
	logic any_valid;
	logic auto_on;
	logic fa_rise;
	logic fa_fall;

	assign fa = frc_s[1];
	assign sd_n = frc_s[0];
	assign any_valid = |lvl_s;
	assign fa_rise = fa & ~st_q.fa_q;
	assign fa_fall = ~fa & st_q.fa_q;
	assign auto_on = ~fa & sd_n;

	// Presence detector: independent of power state
	always_comb begin
		st_d = st_q;
		st_d.fa_q = fa;
		st_d.rxo = rx_s;
		// Count towards the opposite state; reset count when the level agrees
		if (any_valid == st_q.pres) begin
			st_d.pres_cnt = slpd_pkg::PRES_ZERO;
		end else begin
			st_d.pres_cnt = st_q.pres_cnt + 12'h001;
			if (any_valid && st_q.pres_cnt >= 12'(slpd_pkg::VALID_CYC - 1)) begin
				st_d.pres = 1'b1;
				st_d.pres_cnt = slpd_pkg::PRES_ZERO;
			end
			if (!any_valid && st_q.pres_cnt >= 12'(slpd_pkg::INVALID_CYC - 1)) begin
				st_d.pres = 1'b0;
				st_d.pres_cnt = slpd_pkg::PRES_ZERO;
			end
		end

		// Inactivity timer; presence never feeds it directly
		if (act_edge || fa_rise || fa_fall) begin
			st_d.idle_cnt = slpd_pkg::TMR_ZERO;
			st_d.expired = 1'b0;
		end else if (!sd_n) begin
			st_d.expired = 1'b1;
		end else if (!st_q.expired) begin
			if (st_q.idle_cnt >= slpd_pkg::IDLE_CYC - 32'h00000001) begin
				st_d.expired = 1'b1;
			end else begin
				st_d.idle_cnt = st_q.idle_cnt + 32'h00000001;
			end
		end

		// Power state machine; shutdown low dominates everything
		case (st_q.pwr)
			slpd_pkg::PWR_OFF: begin
				st_d.wake_cnt = slpd_pkg::TMR_ZERO;
				if (sd_n && (fa || !st_d.expired)) begin
					st_d.pwr = slpd_pkg::PWR_WAKING;
				end
			end
			slpd_pkg::PWR_WAKING: begin
				st_d.wake_cnt = st_q.wake_cnt + 32'h00000001;
				if (!sd_n || (auto_on && st_d.expired)) begin
					st_d.pwr = slpd_pkg::PWR_OFF;
				end else if (st_q.wake_cnt >= slpd_pkg::WAKE_CYC - 32'h00000001) begin
					st_d.pwr = slpd_pkg::PWR_ON;
				end
			end
			slpd_pkg::PWR_ON: begin
				if (!sd_n) begin
					st_d.pwr = slpd_pkg::PWR_OFF;
				end else if (auto_on && st_d.expired) begin
					st_d.pwr = slpd_pkg::PWR_OFF;
				end
			end
			default: begin
				st_d.pwr = slpd_pkg::PWR_OFF;
			end
		endcase

		// Pump starts on wake; drivers wait for full recovery
		st_d.pump = (st_d.pwr != slpd_pkg::PWR_OFF);
		st_d.drv = (st_d.pwr == slpd_pkg::PWR_ON);
	end

	// Single state register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rx_out = st_q.rxo;
	assign line_present = st_q.pres;
	assign pump_en = st_q.pump;
	assign tx_drive_en = st_q.drv;
	assign tx_oe_n = ~st_q.drv; // Low while driving
	assign powered = st_q.drv;
endmodule

// ===== slpd_monitor.sv
// Checker for power state and presence behaviour at the core ports
module slpd_monitor (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [4:0] rx_data,
	input wire logic [4:0] rx_level_ok,
	input wire logic force_awake,
	input wire logic manual_shutdown_n,
	input wire logic [4:0] rx_out,
	input wire logic line_present,
	input wire logic pump_en,
	input wire logic tx_drive_en,
	input wire logic tx_oe_n,
	input wire logic powered
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_oe; !pump_en |-> tx_oe_n; endproperty
	a_oe: assert property (p_oe) else $error("oe mismatch");
	property p_pw; powered == tx_drive_en; endproperty
	a_pw: assert property (p_pw) else $error("powered mismatch");
	property p_pump; tx_drive_en |-> pump_en; endproperty
	a_pump: assert property (p_pump) else $error("drive without pump");
	property p_shut; (!manual_shutdown_n) [*6] |-> !pump_en; endproperty
	a_shut: assert property (p_shut) else $error("shutdown ignored");
	property p_on; (force_awake && manual_shutdown_n) [*8] |-> pump_en; endproperty
	a_on: assert property (p_on) else $error("force awake ignored");
	property p_wk; $rose(pump_en) |-> !tx_drive_en [*8]; endproperty
	a_wk: assert property (p_wk) else $error("wake delay short");
	property p_rise; $rose(line_present) |-> |$past(rx_level_ok, 20); endproperty
	a_rise: assert property (p_rise) else $error("presence rose early");
	property p_fall; $fell(line_present) |-> $past(rx_level_ok, 300) == 5'h00; endproperty
	a_fall: assert property (p_fall) else $error("presence fell early");
	property p_rx; $stable(rx_data) [*5] |-> rx_out == rx_data; endproperty
	a_rx: assert property (p_rx) else $error("receiver output wrong");
	// Main scenarios reached
	c_up: cover property ($rose(tx_drive_en));
	c_pd: cover property ($fell(line_present));
	c_off: cover property ($fell(pump_en));
endmodule
bind slpd_core slpd_monitor mon (.mclk(mclk), .rst_n(rst_n), .rx_data(rx_data),
	.rx_level_ok(rx_level_ok), .force_awake(force_awake),
	.manual_shutdown_n(manual_shutdown_n), .rx_out(rx_out), .line_present(line_present),
	.pump_en(pump_en), .tx_drive_en(tx_drive_en), .tx_oe_n(tx_oe_n), .powered(powered));

// ===== slpd_host.sv
// Host power logic model driving the two force pins
module slpd_host (
	input wire logic emul,
	input wire logic awake_req,
	input wire logic shut_n_req,
	input wire logic line_present,
	output logic force_awake,
	output logic manual_shutdown_n
);
	// Emulation mode ties presence to both pins
	assign force_awake = emul ? line_present : awake_req;
	assign manual_shutdown_n = emul ? line_present : shut_n_req;
endmodule

// ===== slpd_core_tb_top.sv
// Testbench for the presence detector and powerdown core
module slpd_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic emul = 1'b0;
	logic awk = 1'b1;
	logic shn = 1'b1;
	logic [2:0] tx_in = 3'h0;
	logic [4:0] rx_data = 5'h00;
	logic [4:0] lvl = 5'h00;
	logic [4:0] rx_out;
	logic lp, pump, drv, oe_n, pwd, fa, sdn;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	always #20 mclk = ~mclk;
	slpd_host host (.emul(emul), .awake_req(awk), .shut_n_req(shn), .line_present(lp),
		.force_awake(fa), .manual_shutdown_n(sdn));
	slpd_core dut (.mclk(mclk), .rst_n(rst_n), .tx_in(tx_in), .rx_data(rx_data),
		.rx_level_ok(lvl), .force_awake(fa), .manual_shutdown_n(sdn), .rx_out(rx_out),
		.line_present(lp), .pump_en(pump), .tx_drive_en(drv), .tx_oe_n(oe_n), .powered(pwd));
	task chk(string n, logic [4:0] e, logic [4:0] s);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task close_out;
		$display("fails %0d checks %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task tick(int n);
		repeat (n) @(posedge mclk);
	endtask
	// Presence expected for a set of level flags
	function logic pres(logic [4:0] l);
		return |l;
	endfunction
	// Hang guard, well above the run length
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		void'($urandom(26));
		tick(12);
		rst_n <= 1'b1;
		// Pump first, drivers only after the wake delay
		tick(10);
		chk("pump", 1, pump);
		chk("drv", 0, drv);
		tick(2600);
		chk("drv", 1, drv);
		chk("oe_n", 0, oe_n);
		chk("pwd", 1, pwd);
		// Presence over random levels, last pass under shutdown
		for (int i = 0; i < 3; i++) begin
			shn <= (i != 2);
			lvl <= 5'($urandom) | 5'h01;
			tick(15);
			chk("lp", 0, lp);
			tick(20);
			chk("lp", pres(lvl), lp);
			chk("pump", 5'(i != 2), pump);
			lvl <= 5'h00;
			tick(740);
			chk("lp", 1, lp);
			tick(20);
			chk("lp", 0, lp);
		end
		// Receivers stay live while shut down
		rx_data <= 5'($urandom);
		tick(6);
		chk("rx", rx_data, rx_out);
		awk <= 1'b0;
		tick(6);
		shn <= 1'b1;
		tick(20);
		chk("pump", 0, pump);
		tx_in <= tx_in ^ 3'(1 << ($urandom % 3));
		tick(8);
		chk("pump", 1, pump);
		// Presence wired to both force pins
		emul <= 1'b1;
		tick(10);
		chk("pump", 0, pump);
		lvl <= 5'($urandom) | 5'h10;
		tick(40);
		chk("pump", 1, pump);
		close_out();
	end
endmodule
